// File: design/sler_buf.sv
// Two-entry receive buffer with valid/ready on both sides.
// Assumes one clock and asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sler_buf (
	input wire logic clk,
	input wire logic arst_n,
	sler_buf_if.buffer bus
);
	sler_pkg::sler_data_type mem [0:1];
	sler_pkg::sler_data_type next_mem [0:1];
	logic rd_ptr;
	logic wr_ptr;
	logic [1:0] count;
	logic next_rd_ptr;
	logic next_wr_ptr;
	logic [1:0] next_count;
	logic push;
	logic pop;

	assign bus.in_ready = (count != 2'd2);
	assign bus.out_valid = (count != 2'd0);
	assign bus.out_data = mem[rd_ptr];

	always_comb
	begin
		push = bus.in_valid && bus.in_ready;
		pop = bus.out_valid && bus.out_ready;
		next_mem[0] = mem[0];
		next_mem[1] = mem[1];
		if (push)
		begin
			next_mem[wr_ptr] = bus.in_data;
		end
		next_wr_ptr = push ? ~wr_ptr : wr_ptr;
		next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
		next_count = count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mem[0] <= 8'h00;
			mem[1] <= 8'h00;
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count <= 2'd0;
		end
		else
		begin
			mem[0] <= next_mem[0];
			mem[1] <= next_mem[1];
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count <= next_count;
		end
	end
endmodule : sler_buf
`default_nettype wire

// File: design/sler_buf_if.sv
// Handshake carrier between the error reporting block and its receive buffer.
// Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
interface sler_buf_if;
	logic in_valid;
	logic in_ready;
	sler_pkg::sler_data_type in_data;
	logic out_valid;
	logic out_ready;
	sler_pkg::sler_data_type out_data;
	modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : sler_buf_if
`default_nettype wire

// File: design/sler_defs.svh
// Constants for the serial line error reporting block.
// Assumes inclusion by bare name from design files.
//
// Operation
// (R1) New character before previous finished: overrun code, serial error flag.
// (R2) Stop bits mismatch setting: framing code, serial error flag.
// (R3) Parity mismatch setting: parity code, parity/sum-check flag.
// (R4) Receive buffer full: drop character, buffer full code, serial error flag.
// (R5) Carrier check on, data while carrier off: carrier code, channel error flag.
// (R6) Send request with line down: refuse, transmission code, channel error flag; a request in the cycle after a send is dropped with no refusal, code or flag.
// (R7) Host error clear request clears stored codes and all flags.
// (R8) Host reads and discards bad data after framing or parity error.
// (R9) Host reads ready data promptly to avoid overflow.
// (R10) Both ends use flow control to avoid receive overflow.
// (R11) Far device sends only with carrier active when check enabled.
// (R12) Flags and codes stay latched until the host clear request; the stored code is overwritten by each later error event.
`ifndef SLER_DEFS_SVH
`define SLER_DEFS_SVH
`define SLER_CODE_NONE 16'h0000
`define SLER_CODE_OVERRUN 16'h7F67
`define SLER_CODE_FRAMING 16'h7F68
`define SLER_CODE_PARITY 16'h7F69
`define SLER_CODE_BUF_FULL 16'h7F6A
`define SLER_CODE_CARRIER 16'h7F6B
`define SLER_CODE_TX_LINE 16'h7F6C
`define SLER_DATA_W 8
`define SLER_CODE_W 16
`endif

// File: design/sler_pkg.sv
// Types for the serial line error reporting block.
// Assumes sler_defs.svh is available.
`include "sler_defs.svh"
package sler_pkg;
	typedef logic [`SLER_DATA_W-1:0] sler_data_type;
	typedef logic [`SLER_CODE_W-1:0] sler_code_type;
	typedef enum logic [0:0] {
		SLER_TX_IDLE = 1'b0,
		SLER_TX_SEND = 1'b1
	} sler_tx_state_type;
endpackage : sler_pkg

// File: design/sler_top.sv
// Error detection and latching for one serial channel.
// Assumes a receiver delivering one-cycle character strobes with
// status, and a host reading data with valid/ready.
`include "sler_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sler_top (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic rx_strobe,
	input wire logic [7:0] rx_data,
	input wire logic rx_busy,
	input wire logic rx_stop_bad,
	input wire logic rx_parity_bad,
	input wire logic carrier_detect_pin,
	input wire logic carrier_check_setting,
	input wire logic line_connected,
	input wire logic tx_request,
	input wire logic [7:0] tx_data,
	input wire logic error_clear_request,
	input wire logic host_ready,
	output logic host_valid,
	output logic [7:0] host_data,
	output logic tx_start,
	output logic [7:0] tx_out,
	output logic tx_refused,
	output logic serial_error_flag,
	output logic parity_error_flag,
	output logic channel_error_flag,
	output logic [15:0] error_code
);
	////////////////////////////////////////////////////////////////
	// Pin synchronisers, one per asynchronous pin
	// Only the second stage is read; the first may still be settling
	logic [1:0] pin_raw;
	logic [1:0] pin_sync;
	logic cd_sync;
	logic lc_sync;

	assign pin_raw = {line_connected, carrier_detect_pin};
	assign cd_sync = pin_sync[0];
	assign lc_sync = pin_sync[1];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_sync
			logic meta;
			logic sync;
			logic next_meta;
			logic next_sync;

			always_comb
			begin
				next_meta = pin_raw[gi];
				next_sync = meta;
			end

			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					meta <= 1'b0;
					sync <= 1'b0;
				end
				else
				begin
					meta <= next_meta;
					sync <= next_sync;
				end
			end

			assign pin_sync[gi] = sync;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Receive path
	sler_buf_if bif ();
	sler_buf u_buf (
		.clk(clk),
		.arst_n(arst_n),
		.bus(bif.buffer)
	);

	logic ev_overrun;
	logic ev_framing;
	logic ev_parity;
	logic ev_full;
	logic ev_carrier;
	logic ev_tx;
	logic out_take;

	always_comb
	begin
		// Overrun: new strobe while previous still being processed
		ev_overrun = rx_strobe && rx_busy; // (R1)
		ev_framing = rx_strobe && rx_stop_bad; // (R2)
		ev_parity = rx_strobe && rx_parity_bad; // (R3)
		// Dropped character: buffer cannot take it
		ev_full = rx_strobe && !bif.in_ready; // (R4)
		ev_carrier = rx_strobe && carrier_check_setting && !cd_sync; // (R5)
		ev_tx = tx_request && !lc_sync; // (R6)
		bif.in_valid = rx_strobe; // (R4)
		bif.in_data = rx_data;
		// Output stage empty or being emptied this cycle
		out_take = !host_valid || host_ready; // (R10)
		bif.out_ready = out_take;
	end

	////////////////////////////////////////////////////////////////
	// Host output stage, registered so outputs come from flops
	logic next_host_valid;
	logic [7:0] next_host_data;

	always_comb
	begin
		next_host_valid = host_valid;
		next_host_data = host_data;
		if (out_take)
		begin
			next_host_valid = bif.out_valid;
			if (bif.out_valid)
			begin
				next_host_data = bif.out_data;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			host_valid <= 1'b0;
			host_data <= 8'h00;
		end
		else
		begin
			host_valid <= next_host_valid;
			host_data <= next_host_data;
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmit gate
	sler_pkg::sler_tx_state_type tx_state;
	sler_pkg::sler_tx_state_type next_tx_state;
	logic next_tx_start;
	logic [7:0] next_tx_out;
	logic next_tx_refused;

	always_comb
	begin
		next_tx_state = sler_pkg::SLER_TX_IDLE;
		next_tx_start = 1'b0;
		next_tx_out = tx_out;
		next_tx_refused = 1'b0;
		case (tx_state)
			sler_pkg::SLER_TX_IDLE:
			begin
				if (tx_request && lc_sync)
				begin
					next_tx_state = sler_pkg::SLER_TX_SEND;
					next_tx_start = 1'b1;
					next_tx_out = tx_data;
				end
				else if (ev_tx)
				begin
					// Nothing leaves the pin while the line is down
					next_tx_refused = 1'b1; // (R6)
				end
			end
			sler_pkg::SLER_TX_SEND:
			begin
				next_tx_state = sler_pkg::SLER_TX_IDLE;
			end
			default:
			begin
				next_tx_state = sler_pkg::SLER_TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_state <= sler_pkg::SLER_TX_IDLE;
			tx_start <= 1'b0;
			tx_out <= 8'h00;
			tx_refused <= 1'b0;
		end
		else
		begin
			tx_state <= next_tx_state;
			tx_start <= next_tx_start;
			tx_out <= next_tx_out;
			tx_refused <= next_tx_refused;
		end
	end

	////////////////////////////////////////////////////////////////
	// Error latches; a new event beats a clear in the same cycle
	logic ev_tx_real;
	logic [2:0] flag_set;
	logic [2:0] flag_q;
	logic [15:0] next_code;

	always_comb
	begin
		// Refusal only counts from idle, matching the pulse above
		ev_tx_real = ev_tx && (tx_state == sler_pkg::SLER_TX_IDLE);
		// Bit 2 serial, bit 1 parity/sum-check, bit 0 channel
		flag_set[2] = ev_overrun || ev_framing || ev_full;
		flag_set[1] = ev_parity;
		flag_set[0] = ev_carrier || ev_tx_real;
	end

	// One sticky flag per indicator bit
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_flag
			logic flag;
			logic next_flag;

			always_comb
			begin
				next_flag = flag;
				if (error_clear_request)
				begin
					next_flag = 1'b0; // (R7)
				end
				if (flag_set[gi])
				begin
					next_flag = 1'b1; // (R12)
				end
			end

			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					flag <= 1'b0;
				end
				else
				begin
					flag <= next_flag;
				end
			end

			assign flag_q[gi] = flag;
		end
	endgenerate

	assign serial_error_flag = flag_q[2];
	assign parity_error_flag = flag_q[1];
	assign channel_error_flag = flag_q[0];

	always_comb
	begin
		next_code = error_code;
		if (error_clear_request)
		begin
			next_code = `SLER_CODE_NONE; // (R7)
		end
		// Lowest priority first; last write wins, most severe on top
		if (ev_tx_real)
		begin
			next_code = `SLER_CODE_TX_LINE; // (R6)
		end
		if (ev_carrier)
		begin
			next_code = `SLER_CODE_CARRIER; // (R5)
		end
		if (ev_parity)
		begin
			next_code = `SLER_CODE_PARITY; // (R3)
		end
		if (ev_framing)
		begin
			next_code = `SLER_CODE_FRAMING; // (R2)
		end
		if (ev_full)
		begin
			next_code = `SLER_CODE_BUF_FULL; // (R4)
		end
		if (ev_overrun)
		begin
			next_code = `SLER_CODE_OVERRUN; // (R1)
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			error_code <= `SLER_CODE_NONE;
		end
		else
		begin
			error_code <= next_code;
		end
	end
endmodule : sler_top
`default_nettype wire

// File: tb/sler_host.sv
// Host model: reads received words, stalls on demand.
// Assumes sler_top host port and one clock.
`timescale 1ns/10ps
`default_nettype none
module sler_host (
	input wire logic clk,
	input wire logic stall,
	input wire logic host_valid,
	input wire logic [7:0] host_data,
	output logic host_ready
);
	logic [7:0] got[$];
	initial host_ready = 0;
	// Mostly ready, so paced traffic never overflows
	always @(negedge clk) host_ready <= !stall && ($urandom % 4 != 0);
	always @(posedge clk) if (host_valid && host_ready) got.push_back(host_data);
endmodule : sler_host
`default_nettype wire

// File: tb/sler_sva.sv
// Port checker for sler_top.
// Assumes bind to sler_top, one clock.
`include "sler_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sler_sva (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic rx_strobe,
	input wire logic rx_busy,
	input wire logic rx_stop_bad,
	input wire logic rx_parity_bad,
	input wire logic carrier_detect_pin,
	input wire logic carrier_check_setting,
	input wire logic line_connected,
	input wire logic tx_request,
	input wire logic [7:0] tx_data,
	input wire logic error_clear_request,
	input wire logic host_ready,
	input wire logic host_valid,
	input wire logic [7:0] host_data,
	input wire logic tx_start,
	input wire logic [7:0] tx_out,
	input wire logic tx_refused,
	input wire logic serial_error_flag,
	input wire logic parity_error_flag,
	input wire logic channel_error_flag,
	input wire logic [15:0] error_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Four low cycles outlast the pin synchroniser
	sequence s_cd_off;
		!carrier_detect_pin[*4];
	endsequence
	sequence s_line_off;
		!line_connected[*4];
	endsequence
	AST_OVR: assert property (rx_strobe && rx_busy |=> serial_error_flag
		&& error_code == `SLER_CODE_OVERRUN) else $error("overrun missed");
	AST_FRM: assert property (rx_strobe && rx_stop_bad |=> serial_error_flag)
		else $error("framing missed");
	AST_PAR: assert property (rx_strobe && rx_parity_bad |=> parity_error_flag)
		else $error("parity missed");
	AST_CAR: assert property (s_cd_off ##0 (rx_strobe && carrier_check_setting)
		|=> channel_error_flag) else $error("carrier missed");
	AST_TXN: assert property (s_line_off ##0 tx_request |=> !tx_start)
		else $error("sent with line down");
	AST_TXF: assert property (tx_refused |-> channel_error_flag)
		else $error("refusal without flag");
	AST_TXS: assert property (tx_start |-> $past(tx_request) && tx_out == $past(tx_data))
		else $error("bad send");
	AST_CLR: assert property (error_clear_request && !rx_strobe && !tx_request
		|=> !serial_error_flag && !parity_error_flag && !channel_error_flag && error_code == 0)
		else $error("clear failed");
	AST_HOLD: assert property (serial_error_flag && !error_clear_request
		|=> serial_error_flag) else $error("flag dropped");
	AST_VAL: assert property (host_valid && !host_ready |=> host_valid && $stable(host_data))
		else $error("word lost");
endmodule : sler_sva
bind sler_top sler_sva i_sler_sva (.*);
`default_nettype wire

// File: tb/sler_top_tb.sv
// Bench for sler_top with host model.
// Assumes design files and checker compiled first.
`include "sler_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sler_top_tb;
	logic clk, arst_n, rx_strobe, rx_busy, rx_stop_bad, rx_parity_bad, carrier_detect_pin;
	logic carrier_check_setting, line_connected, tx_request, error_clear_request, host_ready;
	logic host_valid, tx_start, tx_refused, serial_error_flag, parity_error_flag;
	logic channel_error_flag, stall;
	logic [7:0] rx_data, tx_data, host_data, tx_out;
	logic [15:0] error_code;
	logic [7:0] sent[$];
	int fails, compares, k;
	wire [18:0] status = {error_code, serial_error_flag, parity_error_flag, channel_error_flag};
	sler_top i_sler_top (.*);
	sler_host i_sler_host (.clk(clk), .stall(stall), .host_valid(host_valid),
		.host_data(host_data), .host_ready(host_ready));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [18:0] got, input logic [18:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rx(input logic [2:0] st);
		@(negedge clk);
		{rx_busy, rx_stop_bad, rx_parity_bad} = st;
		rx_data = $urandom;
		rx_strobe = 1;
		sent.push_back(rx_data);
		@(negedge clk);
		rx_strobe = 0;
		{rx_busy, rx_stop_bad, rx_parity_bad} = 0;
	endtask : rx
	task automatic clr;
		error_clear_request = 1;
		@(negedge clk);
		error_clear_request = 0;
		chk(status, 19'h0);
	endtask : clr
	task automatic flush;
		repeat (12) @(negedge clk);
		sent.delete();
		i_sler_host.got.delete();
	endtask : flush
	task automatic conclude;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////
	initial
	begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		fails++;
		conclude();
	end
	initial
	begin
		{rx_strobe, rx_busy, rx_stop_bad, rx_parity_bad, tx_request, error_clear_request} = 0;
		{carrier_detect_pin, line_connected, stall, carrier_check_setting, arst_n} = 5'h18;
		{rx_data, tx_data, fails, compares} = 0;
		k = $urandom(41);
		repeat (20) @(negedge clk);
		arst_n = 1;
		repeat (3) @(negedge clk);
		chk(status, 19'h0);
		// Overrun, framing, parity in turn
		for (k = 0; k < 3; k++)
		begin
			rx(3'h4 >> k);
			chk(status, k == 0 ? {`SLER_CODE_OVERRUN, 3'h4} : k == 1 ?
				{`SLER_CODE_FRAMING, 3'h4} : {`SLER_CODE_PARITY, 3'h2});
			repeat (3) @(negedge clk);
			chk(status[2:0], k == 2 ? 3'h2 : 3'h4);
			clr();
		end
		carrier_check_setting = 1;
		carrier_detect_pin = 0;
		repeat (4) @(negedge clk);
		rx(0);
		chk(status, {`SLER_CODE_CARRIER, 3'h1});
		clr();
		carrier_detect_pin = 1;
		repeat (4) @(negedge clk);
		rx(0);
		chk(status, 19'h0);
		tx_data = $urandom;
		tx_request = 1;
		@(negedge clk);
		tx_request = 0;
		chk({tx_refused, tx_start, tx_out}, {2'h1, tx_data});
		line_connected = 0;
		repeat (4) @(negedge clk);
		tx_request = 1;
		@(negedge clk);
		tx_request = 0;
		chk({error_code, tx_refused, tx_start, channel_error_flag}, {`SLER_CODE_TX_LINE, 3'h5});
		line_connected = 1;
		clr();
		stall = 1;
		flush();
		repeat (4) rx(0);
		chk(status, {`SLER_CODE_BUF_FULL, 3'h4});
		stall = 0;
		repeat (12) @(negedge clk);
		chk({i_sler_host.got[0], i_sler_host.got[1]}, {sent[0], sent[1]});
		chk(19'(i_sler_host.got.size()), 19'd3);
		clr();
		flush();
		repeat (40)
		begin
			rx(0);
			repeat ($urandom % 4 + 4) @(negedge clk);
		end
		repeat (12) @(negedge clk);
		chk(19'(i_sler_host.got.size()), 19'(sent.size()));
		foreach (sent[i]) chk({11'h0, i_sler_host.got[i]}, {11'h0, sent[i]});
		chk(status, 19'h0);
		conclude();
	end
endmodule : sler_top_tb
`default_nettype wire
